// [hdl/pad_control.sv]
// One pin's pad stage: decodes direction and configuration into pad controls.
// Assumes the chosen output level and prohibited flag come from the mux.
`timescale 1ns/10ps
module pad_control (
  input wire logic dir_in,
  input wire logic [1:0] cfg,
  input wire logic level,
  input wire logic prohibited,
  output port_mux_pkg::pad_ctrl_t pad
);
  // Configuration meaning depends on direction; inputs never drive.
  always_comb begin
    pad = '0;
    if (dir_in) begin
      pad.pull_down = (cfg == port_mux_pkg::cfg_pch);
      pad.pull_up = (cfg == port_mux_pkg::cfg_nch);
    end else if (prohibited) begin
      pad.oe = (cfg == port_mux_pkg::cfg_nch) || (cfg == port_mux_pkg::cfg_cmos);
      pad.out = 1'b0;
    end else begin
      unique case (cfg)
        port_mux_pkg::cfg_hiz: pad.oe = 1'b0;
        port_mux_pkg::cfg_pch: pad.oe = level;
        port_mux_pkg::cfg_nch: pad.oe = ~level;
        port_mux_pkg::cfg_cmos: pad.oe = 1'b1;
      endcase
      pad.out = level;
    end
  end
endmodule // pad_control

// [hdl/port_mux_pkg.sv]
// Shared constants and carrier types for the port pin function multiplexer.
// Assumes one 25 MHz clock and a single AHB-Lite slave with 32-bit data.
package port_mux_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [15:0] data_addr = 16'hf230;
  localparam logic [15:0] dir_cfg_addr = 16'hf232;
  localparam logic [15:0] func_sel_addr = 16'hf234;
  localparam logic [15:0] func_sel_reset = 16'h0000;
  localparam logic [15:0] cfg_reset = 16'h0000;
  localparam logic [7:0] dir_reset = 8'h00;
  localparam logic [7:0] data_reset = 8'h00;
  localparam int unsigned hi_byte_shift = 8;
  localparam int unsigned pins = 8;

  // ****************************************************************
  // Codes
  // ****************************************************************
  localparam logic [1:0] fn_gpio = 2'h0;
  localparam logic [1:0] fn_second = 2'h1;
  localparam logic [1:0] fn_third = 2'h2;
  localparam logic [1:0] fn_fourth = 2'h3;
  localparam logic [1:0] cfg_hiz = 2'h0;
  localparam logic [1:0] cfg_pch = 2'h1;
  localparam logic [1:0] cfg_nch = 2'h2;
  localparam logic [1:0] cfg_cmos = 2'h3;
  localparam logic [1:0] htrans_nonseq = 2'h2;
  localparam logic [2:0] hsize_byte = 3'h0;
  localparam logic [2:0] hsize_half = 3'h1;

  // Pad controls for one pin: output level, drive enable, pulls.
  typedef struct packed {
    logic out;
    logic oe;
    logic pull_up;
    logic pull_down;
  } pad_ctrl_t;

  // Peripheral signals that may be routed onto the pins.
  typedef struct packed {
    logic i2c_ch0_data;
    logic i2c_ch0_clock;
    logic serial_data_out;
    logic uart_transmit;
    logic serial_clock;
    logic timer_output_ch8;
    logic buzzer_output;
    logic timer_output_ch9;
    logic i2c_ch1_data;
    logic i2c_ch1_clock;
    logic fifo_serial_data_out;
    logic fifo_uart_transmit;
    logic low_speed_clock_out;
    logic fifo_serial_clock;
    logic timer_output_cha;
    logic high_speed_clock_out;
    logic fifo_serial_chip_select;
    logic timer_output_chb;
  } periph_out_t;
endpackage

// [hdl/port_pin_mux.sv]
// Eight-pin function multiplexer with direction, pad configuration and data.
// Assumes a single AHB-Lite master; peripherals are outside this block.
//
// Overview of operation
// - Output direction: config 00 hi-z, 01 P open drain, 10 N open drain, 11 CMOS.
// - Input direction: config 00 hi-z, 01 pull-down, 10 pull-up, 11 hi-z.
// - All configuration bits reset to 00.
// - Configuration meaning follows the pin's direction bit; a peripheral pin whose periph_oe is low is treated as input.
// - Function select is 16-bit RW at 0xf234, byte or halfword, resets zero.
// - Pin n function code is bit n+8 high and bit n low.
// - Code 00 is general I/O with external interrupt, the reset choice.
// - Pin 0: I2C ch0 data, serial data out, UART receive.
// - Pin 1: I2C ch0 clock, serial data in, UART transmit.
// - Pin 2: 10 serial clock, 11 timer ch8; 01 prohibited.
// - Pin 3: 01 buzzer, 11 timer ch9; 10 prohibited.
// - Pin 4: I2C ch1 data, FIFO serial data out, FIFO UART receive.
// - Pin 5: I2C ch1 clock, FIFO serial data in, FIFO UART transmit.
// - Pin 6: low-speed clock, FIFO serial clock, timer channel A.
// - Pin 7: high-speed clock, FIFO serial chip select, timer channel B.
// - Prohibited code with hi-z or P open drain keeps the pad hi-z.
// - Prohibited code with N open drain or CMOS holds the pad low.
// - General output drives each pin from its data register bit.
// - Reading data returns sampled pin levels for input pins.
// - All direction bits reset to 0, output.
`timescale 1ns/10ps
module port_pin_mux (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [7:0] pad_in,
  output logic [7:0] pad_out,
  output logic [7:0] pad_oe,
  output logic [7:0] pad_pull_up,
  output logic [7:0] pad_pull_down,
  input wire port_mux_pkg::periph_out_t periph,
  input wire logic [7:0] periph_oe,
  output logic [7:0] periph_in,
  output logic [7:0] ext_interrupt_in,
  output logic [7:0] pin_function_active
);
  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [15:0] pin_function_select;
  logic [15:0] pad_config;
  logic [7:0] port_direction_register;
  logic [7:0] port_data_register;
  logic [7:0] sampled_pins;
  logic wr_pend;
  logic [15:0] wr_addr;
  logic [2:0] wr_size;
  logic wr_a0;
  logic [7:0] sel_level;
  logic [7:0] prohibited;
  logic [7:0] pin_periph_oe;
  port_mux_pkg::pad_ctrl_t pad_next [8];

  // Function code of pin n from the two register bytes.
  function automatic logic [1:0] code_of(input logic [15:0] sel, input int n);
    code_of = {sel[n + port_mux_pkg::hi_byte_shift], sel[n]};
  endfunction

  // Byte-lane merge shared by the three halfword registers.
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                        input logic [2:0] sz, input logic a0);
    merge = old;
    if (sz == port_mux_pkg::hsize_byte) begin
      if (a0) merge[15:8] = wd[15:8];
      else merge[7:0] = wd[7:0];
    end else begin
      merge = wd;
    end
  endfunction

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  wire logic take = hsel && hready && (htrans == port_mux_pkg::htrans_nonseq);
  wire logic [15:0] word_addr = {haddr[15:2], 2'b00};

  // Zero wait states: address captured, write retired in data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 16'h0000;
      wr_size <= 3'h0;
      wr_a0 <= 1'b0;
    end else begin
      wr_pend <= take && hwrite;
      if (take) begin
        wr_addr <= {haddr[15:1], 1'b0};
        wr_size <= hsize;
        wr_a0 <= haddr[0];
      end
    end
  end

  wire logic [15:0] wlane = wr_addr[1] ? hwdata[31:16] : hwdata[15:0];
  wire logic [15:0] wr_word = (wr_size == port_mux_pkg::hsize_half ||
                               wr_size == port_mux_pkg::hsize_byte) ? wlane : wlane;

  // Function select register, byte or halfword.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_function_select <= port_mux_pkg::func_sel_reset;
    end else if (wr_pend && wr_addr == port_mux_pkg::func_sel_addr) begin
      pin_function_select <= merge(pin_function_select, wr_word, wr_size, wr_a0);
    end
  end

  // Data and direction share one halfword: data low byte, direction high.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_data_register <= port_mux_pkg::data_reset;
      port_direction_register <= port_mux_pkg::dir_reset;
    end else if (wr_pend && wr_addr == port_mux_pkg::data_addr) begin
      {port_direction_register, port_data_register} <=
        merge({port_direction_register, port_data_register}, wr_word, wr_size, wr_a0);
    end
  end

  // Pad configuration halfword.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad_config <= port_mux_pkg::cfg_reset;
    end else if (wr_pend && wr_addr == port_mux_pkg::dir_cfg_addr) begin
      pad_config <= merge(pad_config, wr_word, wr_size, wr_a0);
    end
  end

  // Read data registered in the address phase; unmapped words read zero.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (take && !hwrite) begin
      unique case (word_addr)
        port_mux_pkg::data_addr:
          hrdata <= {pad_config, port_direction_register,
                     (sampled_pins & port_direction_register) |
                     (port_data_register & ~port_direction_register)};
        port_mux_pkg::func_sel_addr: hrdata <= {16'h0000, pin_function_select};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // The slave never stalls and always answers OKAY.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ****************************************************************
  // Function multiplexer
  // ****************************************************************
  // Each pin picks its output level from data or the chosen peripheral.
  always_comb begin
    sel_level = port_data_register;
    prohibited = 8'h00;
    pin_periph_oe = 8'h00;
    for (int n = 0; n < port_mux_pkg::pins; n++) begin
      if (code_of(pin_function_select, n) != port_mux_pkg::fn_gpio) begin
        pin_periph_oe[n] = periph_oe[n];
      end
    end
    unique case (code_of(pin_function_select, 0))
      port_mux_pkg::fn_second: sel_level[0] = periph.i2c_ch0_data;
      port_mux_pkg::fn_third: sel_level[0] = periph.serial_data_out;
      port_mux_pkg::fn_fourth: sel_level[0] = 1'b1;
      default: ;
    endcase
    unique case (code_of(pin_function_select, 1))
      port_mux_pkg::fn_second: sel_level[1] = periph.i2c_ch0_clock;
      port_mux_pkg::fn_third: sel_level[1] = 1'b1;
      port_mux_pkg::fn_fourth: sel_level[1] = periph.uart_transmit;
      default: ;
    endcase
    unique case (code_of(pin_function_select, 2))
      port_mux_pkg::fn_second: prohibited[2] = 1'b1;
      port_mux_pkg::fn_third: sel_level[2] = periph.serial_clock;
      port_mux_pkg::fn_fourth: sel_level[2] = periph.timer_output_ch8;
      default: ;
    endcase
    unique case (code_of(pin_function_select, 3))
      port_mux_pkg::fn_second: sel_level[3] = periph.buzzer_output;
      port_mux_pkg::fn_third: prohibited[3] = 1'b1;
      port_mux_pkg::fn_fourth: sel_level[3] = periph.timer_output_ch9;
      default: ;
    endcase
    unique case (code_of(pin_function_select, 4))
      port_mux_pkg::fn_second: sel_level[4] = periph.i2c_ch1_data;
      port_mux_pkg::fn_third: sel_level[4] = periph.fifo_serial_data_out;
      port_mux_pkg::fn_fourth: sel_level[4] = 1'b1;
      default: ;
    endcase
    unique case (code_of(pin_function_select, 5))
      port_mux_pkg::fn_second: sel_level[5] = periph.i2c_ch1_clock;
      port_mux_pkg::fn_third: sel_level[5] = 1'b1;
      port_mux_pkg::fn_fourth: sel_level[5] = periph.fifo_uart_transmit;
      default: ;
    endcase
    unique case (code_of(pin_function_select, 6))
      port_mux_pkg::fn_second: sel_level[6] = periph.low_speed_clock_out;
      port_mux_pkg::fn_third: sel_level[6] = periph.fifo_serial_clock;
      port_mux_pkg::fn_fourth: sel_level[6] = periph.timer_output_cha;
      default: ;
    endcase
    unique case (code_of(pin_function_select, 7))
      port_mux_pkg::fn_second: sel_level[7] = periph.high_speed_clock_out;
      port_mux_pkg::fn_third: sel_level[7] = periph.fifo_serial_chip_select;
      port_mux_pkg::fn_fourth: sel_level[7] = periph.timer_output_chb;
      default: ;
    endcase
  end

  // ****************************************************************
  // Pad stages
  // ****************************************************************
  // A peripheral pin whose periph_oe is low keeps the pad from driving.
  for (genvar n = 0; n < port_mux_pkg::pins; n++) begin : g_pad
    pad_control u_pad (
      .dir_in(port_direction_register[n] || (code_of(pin_function_select, n) !=
              port_mux_pkg::fn_gpio && !pin_periph_oe[n])),
      .cfg({pad_config[n + port_mux_pkg::hi_byte_shift], pad_config[n]}),
      .level(sel_level[n]),
      .prohibited(prohibited[n]),
      .pad(pad_next[n])
    );
  end

  // Pad outputs are registered so every top output comes from a flop.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad_out <= 8'h00;
      pad_oe <= 8'h00;
      pad_pull_up <= 8'h00;
      pad_pull_down <= 8'h00;
    end else begin
      for (int n = 0; n < port_mux_pkg::pins; n++) begin
        pad_out[n] <= pad_next[n].out;
        pad_oe[n] <= pad_next[n].oe;
        pad_pull_up[n] <= pad_next[n].pull_up;
        pad_pull_down[n] <= pad_next[n].pull_down;
      end
    end
  end

  // Pad inputs are sampled once and routed to GPIO or the chosen peripheral.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sampled_pins <= 8'h00;
      periph_in <= 8'h00;
      ext_interrupt_in <= 8'h00;
      pin_function_active <= 8'h00;
    end else begin
      sampled_pins <= pad_in;
      for (int n = 0; n < port_mux_pkg::pins; n++) begin
        pin_function_active[n] <= code_of(pin_function_select, n) != port_mux_pkg::fn_gpio;
        periph_in[n] <= (code_of(pin_function_select, n) != port_mux_pkg::fn_gpio)
                        && pad_in[n];
        ext_interrupt_in[n] <= (code_of(pin_function_select, n) == port_mux_pkg::fn_gpio)
                               && pad_in[n];
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // Reset values of the function select, pad configuration and direction.
  a_reset_select_zero: assert property (@(posedge hclk)
    $rose(hresetn) |-> pin_function_select == port_mux_pkg::func_sel_reset)
    else $error("select not zero after reset");
  a_cfg_reset_zero: assert property (@(posedge hclk)
    $rose(hresetn) |-> pad_config == port_mux_pkg::cfg_reset &&
    port_direction_register == port_mux_pkg::dir_reset)
    else $error("config or direction not zero");
  // Bus writes land at the edge that ends their data phase; reads answer in the data phase.
  a_write_lands: assert property (@(posedge hclk) disable iff (!hresetn)
    take && hwrite && hsize == port_mux_pkg::hsize_half &&
    haddr[15:0] == port_mux_pkg::func_sel_addr ##1 1'b1 |=>
    pin_function_select == $past(wr_word)) else $error("select write lost");
  a_read_select: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !hwrite && word_addr == port_mux_pkg::func_sel_addr |=>
    hrdata == {16'h0000, $past(pin_function_select)}) else $error("select readback wrong");
  a_read_pins: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !hwrite && word_addr == port_mux_pkg::data_addr && port_direction_register[2] |=>
    hrdata[2] == $past(sampled_pins[2])) else $error("input pin readback wrong");
  // Pad drive for prohibited codes, output settings and input pins.
  a_prohib_low: assert property (@(posedge hclk) disable iff (!hresetn)
    prohibited[2] && !port_direction_register[2] && pad_config[10] |=>
    pad_out[2] == 1'b0 && pad_oe[2]) else $error("prohibited pin not low");
  a_prohib_hiz: assert property (@(posedge hclk) disable iff (!hresetn)
    prohibited[3] && !port_direction_register[3] && !pad_config[11] |=>
    !pad_oe[3]) else $error("prohibited pin drives");
  a_cmos_drive: assert property (@(posedge hclk) disable iff (!hresetn)
    !port_direction_register[0] && pad_config[8] && pad_config[0] && !prohibited[0] |=>
    pad_oe[0] && pad_out[0] == $past(sel_level[0])) else $error("cmos drive wrong");
  a_gpio_output: assert property (@(posedge hclk) disable iff (!hresetn)
    !port_direction_register[1] && code_of(pad_config, 1) == port_mux_pkg::cfg_cmos &&
    code_of(pin_function_select, 1) == port_mux_pkg::fn_gpio |=>
    pad_oe[1] && pad_out[1] == $past(port_data_register[1])) else $error("gpio drive wrong");
  a_timer_route: assert property (@(posedge hclk) disable iff (!hresetn)
    !port_direction_register[7] && code_of(pad_config, 7) == port_mux_pkg::cfg_cmos &&
    code_of(pin_function_select, 7) == port_mux_pkg::fn_fourth |=>
    pad_oe[7] && pad_out[7] == $past(periph.timer_output_chb)) else $error("timer route wrong");
  a_input_no_drive: assert property (@(posedge hclk) disable iff (!hresetn)
    port_direction_register[5] |=> !pad_oe[5]) else $error("input pin drives");
  a_pullup_input: assert property (@(posedge hclk) disable iff (!hresetn)
    port_direction_register[6] && pad_config[14] && !pad_config[6] |=>
    pad_pull_up[6] && !pad_pull_down[6]) else $error("pull-up missing");
  // Pad levels reach either the interrupt input or the peripheral, never both.
  a_gpio_irq_route: assert property (@(posedge hclk) disable iff (!hresetn)
    code_of(pin_function_select, 4) == port_mux_pkg::fn_gpio |=>
    ext_interrupt_in[4] == $past(pad_in[4]) && !periph_in[4]) else $error("interrupt route wrong");
  a_periph_route: assert property (@(posedge hclk) disable iff (!hresetn)
    code_of(pin_function_select, 6) != port_mux_pkg::fn_gpio |=>
    periph_in[6] == $past(pad_in[6]) && !ext_interrupt_in[6]) else $error("peripheral route wrong");
  a_func_active: assert property (@(posedge hclk) disable iff (!hresetn)
    code_of(pin_function_select, 0) != port_mux_pkg::fn_gpio |=> pin_function_active[0])
    else $error("function flag wrong");
  // Main scenarios that the tests are expected to reach.
  c_select_write: cover property (@(posedge hclk)
    take && hwrite && word_addr == port_mux_pkg::func_sel_addr);
  c_prohibited: cover property (@(posedge hclk) prohibited != 8'h00);
  c_input_read: cover property (@(posedge hclk)
    take && !hwrite && word_addr == port_mux_pkg::data_addr);
  c_byte_write: cover property (@(posedge hclk)
    take && hwrite && hsize == port_mux_pkg::hsize_byte);
  c_periph_route: cover property (@(posedge hclk) periph_in != 8'h00);
endmodule // port_pin_mux

// [testbench/periph_board_model.sv]
// Partner model: the on-chip peripherals and the board wiring behind the eight pins.
// Assumes the bench hands it the next peripheral levels and the board's own levels.
`timescale 1ns/10ps
module periph_board_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [17:0] next_levels,
  input wire logic [7:0] board_level,
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  output port_mux_pkg::periph_out_t periph,
  output logic [7:0] periph_oe,
  output logic [7:0] pad_in
);
  // ****************************************************************
  // Peripheral side
  // ****************************************************************
  // Peripheral outputs move just after an edge, as registered sources do.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      periph <= '0;
    end else begin
      periph <= port_mux_pkg::periph_out_t'(next_levels);
    end
  end
  // Every peripheral asks to drive, so only the pad settings decide the pin.
  assign periph_oe = 8'hff;
  // ****************************************************************
  // Board side
  // ****************************************************************
  // A driven pad wins; an undriven pin follows the board source, never a stale value.
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & board_level);
endmodule // periph_board_model

// [testbench/port4_pin_function_mux_tb_top.sv]
// Self-checking bench for the port pin function multiplexer.
// Assumes one AHB-Lite slave whose hreadyout is the bus hready.
`timescale 1ns/10ps
module port4_pin_function_mux_tb_top;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, obs, e, r;
  logic [1:0] htrans, c, m;
  logic [2:0] hsize;
  logic [7:0] pad_in, pad_out, pad_oe, pad_pull_up, pad_pull_down, periph_oe;
  logic [7:0] periph_in, ext_interrupt_in, pin_function_active, dir, data, b, act, lvl;
  logic [15:0] cfg, mode;
  logic [17:0] next_levels;
  logic [7:0] board_level;
  port_mux_pkg::periph_out_t periph;
  logic [31:0] exp_q[$];
  integer seed = 35;
  int err_count = 0;
  int n_compared = 0;
  event got;
  assign hready = hreadyout;
  port_pin_mux dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pad_pull_up),
    .pad_pull_down(pad_pull_down), .periph(periph), .periph_oe(periph_oe),
    .periph_in(periph_in), .ext_interrupt_in(ext_interrupt_in),
    .pin_function_active(pin_function_active));
  periph_board_model partner (.hclk(hclk), .hresetn(hresetn), .next_levels(next_levels),
    .board_level(board_level), .pad_out(pad_out), .pad_oe(pad_oe), .periph(periph),
    .periph_oe(periph_oe), .pad_in(pad_in));
  // ****************************************************************
  // Clock, watchdog and result monitor
  // ****************************************************************
  // The clock runs at 25 MHz.
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // The tests need about 700 cycles; a hang is cut short well beyond that.
  initial begin
    #(40 * 20000);
    err_count++;
    results();
  end
  // Takes the oldest noted expectation whenever a result is seen.
  initial forever begin
    @(got);
    e = exp_q.pop_front();
    n_compared++;
    if (obs !== e) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, obs, e);
    end
  end
  // ****************************************************************
  // Bus and check tasks
  // ****************************************************************
  task automatic note(input logic [31:0] x);
    exp_q.push_back(x);
  endtask
  // The small delay lets the monitor finish before the next result.
  task automatic seen(input logic [31:0] x);
    obs = x;
    -> got;
    #1;
  endtask
  // One single transfer; each phase is held until hready is sampled high.
  task automatic xfer(input logic w, input logic [15:0] a, input logic [2:0] s,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {16'h0000, a};
    htrans <= port_mux_pkg::htrans_nonseq;
    hwrite <= w;
    hsize <= s;
    do begin
      @(posedge hclk);
    end while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge hclk);
    end while (hready !== 1'b1);
    q = hrdata;
  endtask
  // Halfword data goes on both lanes, so either lane choice of the slave sees it.
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    xfer(1'b1, a, port_mux_pkg::hsize_half, {2{v}}, r);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] x);
    note(x);
    xfer(1'b0, a, port_mux_pkg::hsize_half, 32'h0, r);
    seen(r);
  endtask
  // Level that the chosen peripheral role puts on pin p; input-only roles give 1.
  function automatic logic role(input int p, input logic [1:0] f);
    port_mux_pkg::periph_out_t s;
    logic [3:0] v [8];
    s = port_mux_pkg::periph_out_t'(next_levels);
    v[0] = {1'b0, s.i2c_ch0_data, s.serial_data_out, 1'b1};
    v[1] = {1'b0, s.i2c_ch0_clock, 1'b1, s.uart_transmit};
    v[2] = {1'b0, 1'b0, s.serial_clock, s.timer_output_ch8};
    v[3] = {1'b0, s.buzzer_output, 1'b0, s.timer_output_ch9};
    v[4] = {1'b0, s.i2c_ch1_data, s.fifo_serial_data_out, 1'b1};
    v[5] = {1'b0, s.i2c_ch1_clock, 1'b1, s.fifo_uart_transmit};
    v[6] = {1'b0, s.low_speed_clock_out, s.fifo_serial_clock, s.timer_output_cha};
    v[7] = {1'b0, s.high_speed_clock_out, s.fifo_serial_chip_select, s.timer_output_chb};
    return v[p][3 - f];
  endfunction
  // Expected pads packed as pull-up, pull-down, drive enable and driven level.
  function automatic logic [31:0] pad_exp();
    logic [31:0] q;
    logic [1:0] k, f;
    logic lv, pr;
    q = '0;
    for (int i = 0; i < 8; i++) begin
      k = {cfg[8 + i], cfg[i]};
      f = {mode[8 + i], mode[i]};
      pr = (i == 2 && f == 2'h1) || (i == 3 && f == 2'h2);
      lv = (f == 2'h0) ? data[i] : (pr ? 1'b0 : role(i, f));
      if (dir[i]) begin
        q[24 + i] = (k == 2'h2);
        q[16 + i] = (k == 2'h1);
      end else begin
        q[8 + i] = (k == 2'h3) || (k == 2'h2 && !lv) || (k == 2'h1 && lv);
        q[i] = q[8 + i] & lv;
      end
    end
    return q;
  endfunction
  // Programs the state held in the bench, then checks pads, readback and routing.
  task automatic apply();
    next_levels <= 18'($random(seed));
    board_level <= 8'($random(seed));
    wr(port_mux_pkg::data_addr, {dir, data});
    wr(port_mux_pkg::dir_cfg_addr, cfg);
    wr(port_mux_pkg::func_sel_addr, mode);
    repeat (4) @(posedge hclk);
    e = pad_exp();
    lvl = e[7:0] | (~e[15:8] & board_level);
    act = mode[15:8] | mode[7:0];
    note(e);
    seen({pad_pull_up, pad_pull_down, pad_oe, pad_oe & pad_out});
    note({6'h00, 1'b1, 1'b0, act, lvl & act, lvl & ~act});
    seen({6'h00, hreadyout, hresp, pin_function_active, periph_in, ext_interrupt_in});
    rd(port_mux_pkg::data_addr, {cfg, dir, (dir & lvl) | (~dir & data)});
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    next_levels = '0;
    board_level = '0;
    hresetn = 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset leaves every pin an output with floating, unpulled pads.
    note(32'h0);
    seen({pad_pull_up, pad_pull_down, pad_oe, pad_out});
    rd(port_mux_pkg::data_addr, 32'h0);
    rd(port_mux_pkg::func_sel_addr, 32'h0);
    $display("test reset done");
    // Every pad setting in both directions with general I/O.
    mode = 16'h0000;
    for (int k = 0; k < 12; k++) begin
      c = 2'(k % 4);
      cfg = {{8{c[1]}}, {8{c[0]}}};
      dir = 8'($random(seed));
      data = 8'($random(seed));
      apply();
    end
    $display("test pad settings done");
    // Function codes 01 to 11 with every output setting, then random mixes.
    dir = 8'h00;
    for (int k = 0; k < 24; k++) begin
      m = 2'(k % 3 + 1);
      c = 2'(k / 3);
      mode = (k < 12) ? {{8{m[1]}}, {8{m[0]}}} : 16'($random(seed));
      cfg = (k < 12) ? {{8{c[1]}}, {8{c[0]}}} : 16'($random(seed));
      data = 8'($random(seed));
      apply();
    end
    $display("test function codes done");
    // Input pins route their level to interrupt or peripheral by code.
    dir = 8'hff;
    cfg = 16'h0000;
    for (int k = 0; k < 4; k++) begin
      mode = 16'($random(seed));
      apply();
    end
    $display("test input routing done");
    // Byte writes reach only their own half; an unmapped place holds nothing.
    b = 8'($random(seed));
    xfer(1'b1, port_mux_pkg::func_sel_addr + 16'h1, port_mux_pkg::hsize_byte, {4{b}}, r);
    mode[15:8] = b;
    rd(port_mux_pkg::func_sel_addr, {16'h0000, mode});
    b = ~b;
    xfer(1'b1, port_mux_pkg::func_sel_addr, port_mux_pkg::hsize_byte, {4{b}}, r);
    mode[7:0] = b;
    rd(port_mux_pkg::func_sel_addr, {16'h0000, mode});
    wr(16'hf238, 16'hffff);
    rd(16'hf238, 32'h0);
    rd(port_mux_pkg::func_sel_addr, {16'h0000, mode});
    $display("test byte and unmapped done");
    results();
  end
endmodule // port4_pin_function_mux_tb_top
